// ==== rtl/serial_receiver_end.sv ====
// asynchronous serial receiver with two-deep FIFO and AXI4-Lite register slave
// assumes the link line is synchronous to clk_i and one write and one read at most in flight
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "serial_rx_consts.svh"
module serial_receiver_end
	import serial_rx_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset, high
	serial_link_if.receiver link, // serial line in
	input wire logic [7:0] s_awaddr_i, // write address
	input wire logic s_awvalid_i, // write address valid
	output logic s_awready_o, // write address ready
	input wire logic [31:0] s_wdata_i, // write data
	input wire logic [3:0] s_wstrb_i, // write byte strobes
	input wire logic s_wvalid_i, // write data valid
	output logic s_wready_o, // write data ready
	output logic [1:0] s_bresp_o, // write response
	output logic s_bvalid_o, // write response valid
	input wire logic s_bready_i, // write response ready
	input wire logic [7:0] s_araddr_i, // read address
	input wire logic s_arvalid_i, // read address valid
	output logic s_arready_o, // read address ready
	output logic [31:0] s_rdata_o, // read data
	output logic [1:0] s_rresp_o, // read response
	output logic s_rvalid_o, // read data valid
	input wire logic s_rready_i, // read data ready
	output logic irq_o // receive interrupt request, level
);
	typedef struct packed {
		rx_state_t state;
		logic line_prev;
		logic [15:0] baud_cnt;
		logic [3:0] sub;
		logic [3:0] bit_idx;
		logic [1:0] votes;
		logic [8:0] shreg;
		rx_entry_t [`FIFO_DEPTH-1:0] fifo;
		logic rd_ptr;
		logic [1:0] count;
		logic overrun;
		logic serial_port_enable, nine_bit_receive_select, continuous_receive_enable, sync;
		logic global_irq_enable, peripheral_irq_enable, receive_irq_enable, pin_dir, analog;
		logic [15:0] divisor;
		logic aw_held, w_held;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid, rvalid;
		logic [1:0] bresp, rresp;
		logic [31:0] rdata;
	} rx_reg_t;

	rx_reg_t s;
	rx_reg_t next_s;
	logic enabled, tick, maj, receive_irq_flag, pop, push;
	rx_entry_t top, incoming;

	function automatic logic vote3(input logic a, input logic b, input logic c);
		vote3 = (a & b) | (a & c) | (b & c);
	endfunction

	function automatic logic known_addr(input logic [7:0] a);
		known_addr = (a == `REG_RX_STATUS) | (a == `REG_RX_DATA) | (a == `REG_BAUD_LOW)
			| (a == `REG_BAUD_HIGH) | (a == `REG_TX_STATUS) | (a == `REG_INT_CTRL)
			| (a == `REG_PIE_ONE) | (a == `REG_PIR_ONE) | (a == `REG_PORTC_DIR)
			| (a == `REG_ANALOG_SEL);
	endfunction

	// the pin must be an input and digital, else the line never reaches the receiver
	assign enabled = s.continuous_receive_enable & ~s.sync & s.serial_port_enable
		& s.pin_dir & ~s.analog;
	assign tick = (s.baud_cnt == s.divisor);
	assign maj = vote3(s.votes[1], s.votes[0], link.line);
	assign top = s.fifo[s.rd_ptr];
	assign receive_irq_flag = enabled & (s.count != 2'h0);
	assign irq_o = receive_irq_flag & s.receive_irq_enable & s.peripheral_irq_enable
		& s.global_irq_enable;
	assign s_awready_o = ~s.aw_held & ~s.bvalid;
	assign s_wready_o = ~s.w_held & ~s.bvalid;
	assign s_arready_o = ~s.rvalid;
	assign s_bvalid_o = s.bvalid;
	assign s_bresp_o = s.bresp;
	assign s_rvalid_o = s.rvalid;
	assign s_rresp_o = s.rresp;
	assign s_rdata_o = s.rdata;
	assign pop = s_arvalid_i & ~s.rvalid & (s_araddr_i == `REG_RX_DATA)
		& (s.count != 2'h0);
	assign incoming.framing_error_flag = ~maj;
	assign incoming.ninth = s.nine_bit_receive_select ? s.shreg[8] : 1'b0;
	assign incoming.data = s.nine_bit_receive_select ? s.shreg[7:0] : s.shreg[8:1];
	assign push = (s.state == RX_STOP) & tick & (s.sub == `VOTE_LAST) & (s.count != 2'h2);

	always_comb begin
		logic [7:0] wa;
		logic [7:0] wb;
		wa = s_awvalid_i & ~s.aw_held ? s_awaddr_i : s.awaddr;
		wb = s_wvalid_i & ~s.w_held ? s_wdata_i[7:0] : s.wdata[7:0];
		next_s = s;
		next_s.line_prev = link.line;

		// receive state machine
		next_s.baud_cnt = tick ? 16'h0000 : s.baud_cnt + 16'h0001;
		if (tick) begin
			next_s.sub = s.sub + 4'h1;
			if (s.sub == `VOTE_FIRST || s.sub == `VOTE_MID) begin
				next_s.votes = {s.votes[0], link.line};
			end
		end
		unique case (s.state)
			RX_IDLE: begin
				// overrun keeps the receiver deaf until cleared
				if (enabled & ~s.overrun & s.line_prev & ~link.line) begin
					next_s.state = RX_START;
					next_s.baud_cnt = 16'h0000;
					next_s.sub = 4'h0;
					next_s.bit_idx = 4'h0;
				end
			end
			RX_START: begin
				if (tick && s.sub == `VOTE_LAST && maj) begin
					next_s.state = RX_IDLE;
				end else if (tick && s.sub == 4'hF) begin
					next_s.state = RX_DATA;
				end
			end
			RX_DATA: begin
				if (tick && s.sub == `VOTE_LAST) begin
					next_s.shreg = {maj, s.shreg[8:1]};
					next_s.bit_idx = s.bit_idx + 4'h1;
				end else if (tick && s.sub == 4'hF
					&& s.bit_idx == (s.nine_bit_receive_select ? 4'h9 : 4'h8)) begin
					next_s.state = RX_STOP;
				end
			end
			RX_STOP: begin
				if (tick && s.sub == `VOTE_LAST) begin
					next_s.state = RX_IDLE;
					if (s.count == 2'h2) begin
						next_s.overrun = 1'b1;
					end
				end
			end
		endcase
		if (!enabled) begin
			next_s.state = RX_IDLE;
		end

		// fifo: a push beside a pop (one entry held) lands at the old tail, the new head
		if (pop) begin
			next_s.rd_ptr = ~s.rd_ptr;
		end
		if (push) begin
			next_s.fifo[s.rd_ptr ^ s.count[0]] = incoming;
		end
		next_s.count = s.count + {1'b0, push} - {1'b0, pop};

		// write channel
		if (s_awvalid_i & ~s.aw_held & ~s.bvalid) begin
			next_s.aw_held = 1'b1;
			next_s.awaddr = s_awaddr_i;
		end
		if (s_wvalid_i & ~s.w_held & ~s.bvalid) begin
			next_s.w_held = 1'b1;
			next_s.wdata = s_wdata_i;
			next_s.wstrb = s_wstrb_i;
		end
		if ((s.aw_held | s_awvalid_i) & (s.w_held | s_wvalid_i) & ~s.bvalid) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = known_addr(wa) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
			if ((s.w_held ? s.wstrb[0] : s_wstrb_i[0])) begin
				unique case (wa)
					`REG_RX_STATUS: begin
						next_s.serial_port_enable = wb[`BIT_SERIAL_PORT_ENABLE];
						next_s.nine_bit_receive_select = wb[`BIT_NINE_BIT_RECEIVE_SELECT];
						next_s.continuous_receive_enable = wb[`BIT_CONTINUOUS_RECEIVE_ENABLE];
					end
					`REG_BAUD_LOW: next_s.divisor[7:0] = wb;
					`REG_BAUD_HIGH: next_s.divisor[15:8] = wb;
					`REG_TX_STATUS: next_s.sync = wb[`BIT_SYNC];
					`REG_INT_CTRL: begin
						next_s.global_irq_enable = wb[`BIT_GLOBAL_IRQ_ENABLE];
						next_s.peripheral_irq_enable = wb[`BIT_PERIPHERAL_IRQ_ENABLE];
					end
					`REG_PIE_ONE: next_s.receive_irq_enable = wb[`BIT_RECEIVE_IRQ_ENABLE];
					`REG_PORTC_DIR: next_s.pin_dir = wb[`BIT_RX_PIN];
					`REG_ANALOG_SEL: next_s.analog = wb[`BIT_RX_PIN];
					// flag register and data register ignore writes
					default: next_s.bresp = known_addr(wa) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
				endcase
			end
		end
		if (s.bvalid & s_bready_i) begin
			next_s.bvalid = 1'b0;
		end
		// overrun is the only flag cleared by software, and only by dropping receive enable
		if (!next_s.continuous_receive_enable) begin
			next_s.overrun = 1'b0;
		end

		// read channel
		if (s_arvalid_i & ~s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = known_addr(s_araddr_i) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
			next_s.rdata = 32'h00000000;
			unique case (s_araddr_i)
				`REG_RX_STATUS: next_s.rdata[7:0] = {s.serial_port_enable,
					s.nine_bit_receive_select, 1'b0, s.continuous_receive_enable, 1'b0,
					top.framing_error_flag, s.overrun, top.ninth};
				`REG_RX_DATA: next_s.rdata[7:0] = top.data;
				`REG_BAUD_LOW: next_s.rdata[7:0] = s.divisor[7:0];
				`REG_BAUD_HIGH: next_s.rdata[7:0] = s.divisor[15:8];
				`REG_TX_STATUS: next_s.rdata[`BIT_SYNC] = s.sync;
				`REG_INT_CTRL: next_s.rdata[7:0] = {s.global_irq_enable, s.peripheral_irq_enable,
					6'h00};
				`REG_PIE_ONE: next_s.rdata[`BIT_RECEIVE_IRQ_ENABLE] = s.receive_irq_enable;
				`REG_PIR_ONE: next_s.rdata[`BIT_RECEIVE_IRQ_FLAG] = receive_irq_flag;
				`REG_PORTC_DIR: next_s.rdata[`BIT_RX_PIN] = s.pin_dir;
				`REG_ANALOG_SEL: next_s.rdata[`BIT_RX_PIN] = s.analog;
				default: next_s.rdata = 32'h00000000;
			endcase
		end
		if (s.rvalid & s_rready_i) begin
			next_s.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.state <= RX_IDLE;
			s.line_prev <= 1'b1;
			s.divisor <= `BAUD_DIV_RESET;
			s.pin_dir <= 1'b1;
			s.analog <= 1'b0;
		end else begin
			s <= next_s;
		end
	end
endmodule // serial_receiver_end

// ==== rtl/serial_rx_consts.svh ====
// constants for the asynchronous serial receiver and its remote transmitter
// assumes a 100 MHz system clock and word-aligned register access
// Contract
// - sample line at sixteen times baud rate
// - finished character goes to two-deep FIFO
// - two held characters while third shifts
// - characters reached only through receive data
// - receive only when enabled, async, port on
// - software sets receive pin as input
// - software clears analog select on pin
// - falling edge starts character, start is zero
// - half bit later check start still low
// - false start dropped silently, await edge
// - full bit steps, majority vote, shift in
// - stop bit zero sets framing error
// - after stop push character, raise flag
// - data read returns and drops oldest
// - overrun blocks reception until cleared
// - flag set while enabled and FIFO nonempty
// - flag read-only, follows FIFO occupancy
// - request needs all three enable bits
// - flag independent of interrupt enables
`ifndef SERIAL_RX_CONSTS_SVH
`define SERIAL_RX_CONSTS_SVH

`define CLK_PERIOD_NS 10
`define OVERSAMPLE 16
`define VOTE_FIRST 4'h7
`define VOTE_MID 4'h8
`define VOTE_LAST 4'h9
`define FIFO_DEPTH 2
`define BAUD_DIV_RESET 16'h0000

`define REG_RX_STATUS 8'h00
`define REG_RX_DATA 8'h04
`define REG_BAUD_LOW 8'h08
`define REG_BAUD_HIGH 8'h0C
`define REG_TX_STATUS 8'h10
`define REG_INT_CTRL 8'h14
`define REG_PIE_ONE 8'h18
`define REG_PIR_ONE 8'h1C
`define REG_PORTC_DIR 8'h20
`define REG_ANALOG_SEL 8'h24

`define BIT_SERIAL_PORT_ENABLE 7
`define BIT_NINE_BIT_RECEIVE_SELECT 6
`define BIT_CONTINUOUS_RECEIVE_ENABLE 4
`define BIT_FRAMING_ERROR_FLAG 2
`define BIT_OVERRUN_ERROR_FLAG 1
`define BIT_NINTH_RECEIVED_BIT 0
`define BIT_SYNC 4
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_PERIPHERAL_IRQ_ENABLE 6
`define BIT_RECEIVE_IRQ_ENABLE 5
`define BIT_RECEIVE_IRQ_FLAG 5
`define BIT_RX_PIN 7
`define PORTC_DIR_RESET 8'hFF
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// ==== rtl/serial_rx_pkg.sv ====
// types shared by both ends of the serial link
// assumes serial_rx_consts.svh for all numeric constants
package serial_rx_pkg;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
	typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
	// fifo entry: framing error, ninth bit, data byte
	typedef struct packed {
		logic framing_error_flag;
		logic ninth;
		logic [7:0] data;
	} rx_entry_t;
endpackage

// ==== rtl/serial_link_if.sv ====
// one-wire asynchronous serial link, idle high
// assumes the transmitter end drives the line from reset onward
`timescale 1ns/1ps
interface serial_link_if;
	logic line;
	modport transmitter (output line);
	modport receiver (input line);
endinterface // serial_link_if

// ==== rtl/serial_transmitter_end.sv ====
// remote transmitter: frames characters onto the serial link
// assumes a user that holds data and valid until ready; baud divisor held steady per frame
`timescale 1ns/1ps
`include "serial_rx_consts.svh"
module serial_transmitter_end
	import serial_rx_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset, high
	serial_link_if.transmitter link, // serial line out
	input wire logic [15:0] divisor_i, // 16x tick every divisor+1 clocks
	input wire logic nine_bit_i, // send nine data bits
	input wire logic bad_stop_i, // send stop bit as zero
	input wire logic [8:0] data_i, // character, lsb first
	input wire logic valid_i, // character offered
	output logic ready_o // character taken this cycle
);
	typedef struct packed {
		tx_state_t state;
		logic [15:0] baud_cnt;
		logic [3:0] sub;
		logic [3:0] bit_idx;
		logic [3:0] last_idx;
		logic [11:0] shreg;
		logic line;
	} tx_reg_t;

	tx_reg_t s;
	tx_reg_t next_s;
	logic tick;

	assign ready_o = (s.state == TX_IDLE) & valid_i;
	assign link.line = s.line;
	assign tick = (s.baud_cnt == divisor_i);

	always_comb begin
		next_s = s;
		next_s.baud_cnt = tick ? 16'h0000 : s.baud_cnt + 16'h0001;
		unique case (s.state)
			TX_IDLE: begin
				next_s.line = 1'b1;
				if (valid_i) begin
					// start, data bits, stop bit, then idle-high pad
					next_s.shreg = nine_bit_i ? {1'b1, ~bad_stop_i, data_i, 1'b0}
						: {2'b11, ~bad_stop_i, data_i[7:0], 1'b0};
					next_s.last_idx = nine_bit_i ? 4'hA : 4'h9;
					next_s.bit_idx = 4'h0;
					next_s.sub = 4'h0;
					next_s.baud_cnt = 16'h0000;
					next_s.line = 1'b0;
					next_s.state = TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				if (tick) begin
					next_s.sub = s.sub + 4'h1;
					if (s.sub == 4'hF) begin
						if (s.bit_idx == s.last_idx) begin
							next_s.state = TX_IDLE;
							next_s.line = 1'b1;
						end else begin
							next_s.bit_idx = s.bit_idx + 4'h1;
							next_s.shreg = {1'b1, s.shreg[11:1]};
							next_s.line = s.shreg[1];
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.state <= TX_IDLE;
			s.line <= 1'b1;
		end else begin
			s <= next_s;
		end
	end
endmodule // serial_transmitter_end

// ==== verification/serial_link_sva.sv ====
// checks on the serial line joining the transmitter end to the receiver end
// assumes divisor 0, so one bit lasts 16 clocks from the cycle after the take
`timescale 1ns/1ps
module serial_link_sva (
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic line, // serial line
	input wire logic valid_i, // offer
	input wire logic ready_o, // taken
	input wire logic [8:0] data_i, // character
	input wire logic [15:0] divisor_i, // divisor
	input wire logic nine_bit_i, // nine bits
	input wire logic bad_stop_i // zero stop
);
	logic take;
	// other divisors only stretch the frame, so they are left out of the timing checks
	assign take = valid_i && ready_o && divisor_i == 16'h0000;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	idle_high_a: assert property ($fell(rst_i) |-> line)
		else $error("line low after reset");
	start_low_a: assert property (take |=> !line [*8] ##1 !line [*8])
		else $error("start bit short");
	first_bit_a: assert property (take |-> ##24 line == $past(data_i[0], 24))
		else $error("bit 0 wrong");
	last_bit_a: assert property (take |-> ##136 line == $past(data_i[7], 136))
		else $error("bit 7 wrong");
	stop_high_a: assert property (take && !nine_bit_i && !bad_stop_i |-> ##152 line)
		else $error("stop bit low");
	stop_low_a: assert property (take && !nine_bit_i && bad_stop_i |-> ##152 !line)
		else $error("forced stop high");
	ninth_bit_a: assert property (take && nine_bit_i |->
		##152 line == $past(data_i[8], 152)) else $error("bit 8 wrong");
	nine_stop_a: assert property (take && nine_bit_i && !bad_stop_i |->
		##168 line) else $error("nine bit stop low");
	cover property (take && bad_stop_i);
	cover property (take && nine_bit_i);
	cover property (take && !nine_bit_i && !bad_stop_i);
endmodule // serial_link_sva

// ==== verification/test_async_serial_receiver.sv ====
// bench: transmitter end frames characters to the receiver end, registers over AXI4-Lite
// assumes divisor 0 unless a scenario says otherwise: a frame lands within the 200 clocks that frame() waits after its take
`timescale 1ns/1ps
`include "serial_rx_consts.svh"
module test_async_serial_receiver
	import serial_rx_pkg::*;
;
	logic clk_i, rst_i, nine_bit_i, bad_stop_i, valid_i, ready_o, irq_o;
	logic s_awvalid_i, s_awready_o, s_wvalid_i, s_wready_o, s_bvalid_o, s_bready_i;
	logic s_arvalid_i, s_arready_o, s_rvalid_o, s_rready_i;
	logic [1:0] s_bresp_o, s_rresp_o, resp;
	logic [3:0] s_wstrb_i;
	logic [7:0] s_awaddr_i, s_araddr_i;
	logic [8:0] data_i;
	logic [15:0] divisor_i;
	logic [31:0] s_wdata_i, s_rdata_o, got;
	int bad_count, n_tests;
	logic [7:0] ga[4] = '{`REG_RX_STATUS, `REG_TX_STATUS, `REG_PORTC_DIR, `REG_ANALOG_SEL};
	logic [7:0] gv[4] = '{8'h80, 8'h10, 8'h00, 8'h80};
	logic [7:0] gr[4] = '{8'h90, 8'h00, 8'hFF, 8'h00};
	serial_link_if serial_link_if_inst ();
	serial_transmitter_end serial_transmitter_end_inst (
		.link(serial_link_if_inst.transmitter), .*);
	serial_receiver_end serial_receiver_end_inst (.link(serial_link_if_inst.receiver), .*);
	serial_link_sva serial_link_sva_inst (.line(serial_link_if_inst.line), .*);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk_i);
		s_awaddr_i <= a;
		s_wdata_i <= d;
		s_awvalid_i <= 1'b1;
		s_wvalid_i <= 1'b1;
		s_bready_i <= 1'b1;
		// each channel is released at its own handshake, in whichever order the slave takes them
		while (!(aw_done && w_done)) begin
			@(posedge clk_i);
			if (!aw_done && s_awready_o) begin
				aw_done = 1'b1;
				s_awvalid_i <= 1'b0;
			end
			if (!w_done && s_wready_o) begin
				w_done = 1'b1;
				s_wvalid_i <= 1'b0;
			end
		end
		@(posedge clk_i iff s_bvalid_o);
		s_bready_i <= 1'b0;
		chk(32'(s_bresp_o), 32'(`AXI_RESP_OKAY));
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		s_araddr_i <= a;
		s_arvalid_i <= 1'b1;
		@(posedge clk_i iff s_arready_o);
		s_arvalid_i <= 1'b0;
		s_rready_i <= 1'b1;
		@(posedge clk_i iff s_rvalid_o);
		d = s_rdata_o;
		r = s_rresp_o;
		s_rready_i <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a, got, resp);
		chk(got, e);
	endtask
	task automatic send(input logic [8:0] d, input logic n, input logic b);
		@(posedge clk_i);
		data_i <= d;
		nine_bit_i <= n;
		bad_stop_i <= b;
		valid_i <= 1'b1;
		@(posedge clk_i iff ready_o);
		valid_i <= 1'b0;
	endtask
	task automatic frame();
		repeat (200) @(posedge clk_i);
	endtask
	task automatic t_reset();
		rdc(`REG_RX_STATUS, 32'h0);
		rdc(`REG_PORTC_DIR, 32'(`PORTC_DIR_RESET & 8'h80));
		rd(8'h30, got, resp);
		chk(32'(resp), 32'(`AXI_RESP_SLVERR));
		wr(`REG_RX_DATA, 32'h55);
		rdc(`REG_PIR_ONE, 32'h0);
	endtask
	task automatic t_one();
		wr(`REG_INT_CTRL, 32'hC0);
		wr(`REG_PIE_ONE, 32'h20);
		wr(`REG_RX_STATUS, 32'h90);
		send(9'h0A5, 1'b0, 1'b0);
		frame();
		chk(32'(irq_o), 32'h1);
		wr(`REG_PIR_ONE, 32'h0);
		rdc(`REG_PIR_ONE, 32'h20);
		rdc(`REG_RX_DATA, 32'hA5);
		rdc(`REG_PIR_ONE, 32'h0);
		chk(32'(irq_o), 32'h0);
	endtask
	task automatic t_overrun();
		send(9'h011, 1'b0, 1'b0);
		send(9'h022, 1'b0, 1'b0);
		send(9'h033, 1'b0, 1'b0);
		frame();
		rdc(`REG_RX_STATUS, 32'h92);
		rdc(`REG_RX_DATA, 32'h11);
		rdc(`REG_RX_DATA, 32'h22);
		send(9'h044, 1'b0, 1'b0);
		frame();
		rdc(`REG_PIR_ONE, 32'h0);
		wr(`REG_RX_STATUS, 32'h80);
		wr(`REG_RX_STATUS, 32'h90);
		rdc(`REG_RX_STATUS, 32'h90);
		send(9'h055, 1'b0, 1'b0);
		frame();
		rdc(`REG_RX_DATA, 32'h55);
	endtask
	task automatic t_frame();
		send(9'h0F0, 1'b0, 1'b1);
		// a zero stop joined to the next start would hide its falling edge
		frame();
		send(9'h00F, 1'b0, 1'b0);
		frame();
		rdc(`REG_RX_STATUS, 32'h94);
		rdc(`REG_RX_DATA, 32'hF0);
		rdc(`REG_RX_STATUS, 32'h90);
		rdc(`REG_RX_DATA, 32'h0F);
	endtask
	task automatic t_nine();
		wr(`REG_RX_STATUS, 32'hD0);
		send(9'h13C, 1'b1, 1'b0);
		frame();
		rdc(`REG_RX_STATUS, 32'hD1);
		rdc(`REG_RX_DATA, 32'h3C);
		wr(`REG_RX_STATUS, 32'h90);
	endtask
	task automatic t_gate();
		wr(`REG_PIE_ONE, 32'h0);
		send(9'h066, 1'b0, 1'b0);
		frame();
		rdc(`REG_PIR_ONE, 32'h20);
		chk(32'(irq_o), 32'h0);
		wr(`REG_PIE_ONE, 32'h20);
		chk(32'(irq_o), 32'h1);
		wr(`REG_INT_CTRL, 32'h40);
		chk(32'(irq_o), 32'h0);
		rdc(`REG_RX_DATA, 32'h66);
		for (int i = 0; i < 4; i++) begin
			wr(ga[i], 32'(gv[i]));
			send(9'h077, 1'b0, 1'b0);
			frame();
			wr(ga[i], 32'(gr[i]));
			rdc(`REG_PIR_ONE, 32'h0);
		end
	endtask
	task automatic t_baud();
		// a receiver four times slower finds the short start bit high at its centre
		wr(`REG_BAUD_LOW, 32'h03);
		send(9'h0FF, 1'b0, 1'b0);
		frame();
		rdc(`REG_PIR_ONE, 32'h0);
		wr(`REG_BAUD_LOW, 32'h01);
		rdc(`REG_BAUD_LOW, 32'h01);
		divisor_i <= 16'h0001;
		send(9'h05A, 1'b0, 1'b0);
		frame();
		frame();
		rdc(`REG_RX_DATA, 32'h5A);
		divisor_i <= 16'h0000;
		s_wstrb_i <= 4'hE;
		wr(`REG_BAUD_LOW, 32'h00);
		s_wstrb_i <= 4'hF;
		rdc(`REG_BAUD_LOW, 32'h01);
		wr(`REG_BAUD_LOW, 32'h00);
		rdc(`REG_BAUD_HIGH, 32'h00);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		repeat (30000) @(posedge clk_i);
		bad_count++;
		results();
	end
	initial begin
		rst_i = 1'b1;
		s_wstrb_i = 4'hF;
		{valid_i, nine_bit_i, bad_stop_i, s_awvalid_i, s_wvalid_i} = '0;
		{s_bready_i, s_arvalid_i, s_rready_i} = '0;
		{s_awaddr_i, s_araddr_i, s_wdata_i, data_i, divisor_i} = '0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_one();
		t_overrun();
		t_frame();
		t_nine();
		t_gate();
		t_baud();
		results();
	end
endmodule // test_async_serial_receiver
